// ### design/pdo_pkg.sv
// Package for the PWM DAC output block: constants and carrier structs.
// Assumes a single system clock and a port-style write/read interface.
package pdo_pkg;
  localparam int PDO_NARROW_N = 9;
  localparam int PDO_WIDE_W = 14;
  localparam int PDO_NARROW_W = 7;
  localparam int PDO_BUF_N = 11;
  localparam int PDO_WIDE_PERIOD_LOG2 = 15;
  localparam int PDO_NARROW_PERIOD_LOG2 = 8;
  localparam logic [3:0] PDO_SEL_WIDE_LO = 4'h0;
  localparam logic [3:0] PDO_SEL_WIDE_HI = 4'h1;
  localparam logic [3:0] PDO_SEL_NARROW_FIRST = 4'h2;
  localparam logic [3:0] PDO_SEL_NARROW_LAST = 4'ha;
  localparam logic [3:0] PDO_SEL_TRANSFER = 4'hc;
  localparam logic [3:0] PDO_SEL_RESET = 4'h0;
  localparam logic [6:0] PDO_BUF_RESET = 7'h00;
  localparam logic [9:0] PDO_PORT_LATCH_RESET = 10'h3ff;
  localparam int PDO_STATUS_BIT = 0;

  typedef struct packed {
    logic wr;
    logic [3:0] data;
  } pdo_wr_type;

  typedef struct packed {
    logic [3:0] sel;
    logic second;
    logic [PDO_BUF_N-1:0][7:0] buf_q;
    logic [PDO_WIDE_W-1:0] wide_lat;
    logic [PDO_NARROW_N-1:0][PDO_NARROW_W-1:0] nar_lat;
    logic pend_w;
    logic pend_n;
    logic busy;
    logic [PDO_WIDE_PERIOD_LOG2-1:0] cnt;
    logic wide_out;
    logic [PDO_NARROW_N-1:0] nar_out;
    logic [9:0] port_latch;
  } pdo_state_type;
endpackage

// ### design/pdo_pwm_dac.sv
// PWM DAC outputs: one 14-bit and nine 7-bit active-low PWM channels.
// Assumes same-clock port strobes from the CPU core and a hold input.
// Function
// [R01] Software keeps shared port latch bits at one for PWM to reach pins.
// [R02] Reset sets the shared port latch bits to one.
// [R03] Writing code C to selector copies all buffers into output latches.
// [R04] Output latches keep their value until the next transfer.
// [R05] Reset and hold clear selector, buffers and output latches.
// [R06] Wide channel uses 14 bits over 2^15 clocks in 64 sub-periods.
// [R07] Each wide sub-period pulse is upper byte n times two clocks.
// [R08] Low six bits widen the pulse by one unit in m sub-periods.
// [R09] Each low bit selects fixed sub-periods by bit-reversed position.
// [R10] Narrow channels: pulse k times two clocks in 2^8 clock period.
// [R11] Software writes selector, then low nibble, then upper nibble.
// [R12] Buffer numbers map to wide halves and narrow channels; C transfers.
// [R13] Status bit zero reads one while a transfer is pending.
// [R14] Software must not write data while the status reads one.
// [R15] Outputs keep running from old latches while buffers load.
// [R16] Outputs switch at their own period boundary after transfer.
// [R17] Outputs are active low: pulse interval drives the pin low.
module pdo_pwm_dac (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic hold_i,
  input wire pdo_pkg::pdo_wr_type buffer_select_port_i,
  input wire pdo_pkg::pdo_wr_type transfer_buffer_port_i,
  input wire logic [9:0] port_latch_wdata_i,
  input wire logic port_latch_wr_i,
  output logic [3:0] transfer_status_port_o,
  output logic wide_channel_out_o,
  output logic [pdo_pkg::PDO_NARROW_N-1:0] narrow_channel_out_o,
  output logic [9:0] port_latch_o
);
  import pdo_pkg::*;

  pdo_state_type state_r;
  pdo_state_type state_nxt;
  logic [5:0] sub_idx;
  logic [8:0] sub_pos;
  logic [5:0] slot_hit;
  logic wide_extra;
  logic [7:0] nar_pos;
  logic wide_wrap;
  logic nar_wrap;
  logic [PDO_NARROW_N-1:0] nar_pulse;

  // Sub-period index and position within it
  assign sub_idx = state_r.cnt[14:9];
  assign sub_pos = state_r.cnt[8:0];
  assign nar_pos = state_r.cnt[7:0];
  assign wide_wrap = (state_r.cnt == 15'h7fff);
  assign nar_wrap = (nar_pos == 8'hff);

  // [R09] Bit s owns sub-periods whose lowest set bit is 5-s
  genvar s;
  generate
    for (s = 0; s < 6; s++) begin : g_slot
      assign slot_hit[s] = state_r.wide_lat[s] &&
        ((sub_idx & (6'h3f >> s)) == (6'h20 >> s));
    end
  endgenerate

  // [R08] Extra unit in m of 64 sub-periods
  assign wide_extra = |slot_hit;

  genvar g;
  generate
    for (g = 0; g < PDO_NARROW_N; g++) begin : g_nar
      // [R10] Narrow pulse k times two clocks
      assign nar_pulse[g] = ({1'b0, nar_pos} <
                             {1'b0, state_r.nar_lat[g], 1'b0});
    end
  endgenerate

  always_comb begin
    state_nxt = state_r;
    // [R06] Free-running period counter
    state_nxt.cnt = state_r.cnt + 15'h0001;
    // [R07] Base width plus extra unit
    state_nxt.wide_out = ~(({1'b0, sub_pos}) <
      ({1'b0, state_r.wide_lat[13:6], 1'b0} +
       {8'h00, wide_extra, 1'b0}));
    // [R17] Active-low narrow outputs
    state_nxt.nar_out = ~nar_pulse;
    if (port_latch_wr_i) begin
      state_nxt.port_latch = port_latch_wdata_i;
    end
    // [R11] Two-write sequence after selection
    if (buffer_select_port_i.wr) begin
      state_nxt.sel = buffer_select_port_i.data;
      state_nxt.second = 1'b0;
      // [R03] Transfer command arms latches
      if (buffer_select_port_i.data == PDO_SEL_TRANSFER) begin
        state_nxt.pend_w = 1'b1;
        state_nxt.pend_n = 1'b1;
      end
    end else if (transfer_buffer_port_i.wr) begin
      // [R12] Buffer number decode
      if (state_r.sel <= PDO_SEL_NARROW_LAST) begin
        if (!state_r.second) begin
          state_nxt.buf_q[state_r.sel][3:0] = transfer_buffer_port_i.data;
        end else if (state_r.sel == PDO_SEL_WIDE_LO) begin
          state_nxt.buf_q[state_r.sel][5:4] =
            transfer_buffer_port_i.data[1:0];
        end else if (state_r.sel == PDO_SEL_WIDE_HI) begin
          state_nxt.buf_q[state_r.sel][7:4] = transfer_buffer_port_i.data;
        end else begin
          state_nxt.buf_q[state_r.sel][6:4] =
            transfer_buffer_port_i.data[2:0];
        end
        state_nxt.second = ~state_r.second;
      end
    end
    // [R16] Wide switches at its period boundary
    if (state_r.pend_w && wide_wrap) begin
      state_nxt.wide_lat = {state_r.buf_q[PDO_SEL_WIDE_HI],
        state_r.buf_q[PDO_SEL_WIDE_LO][5:0]};
      state_nxt.pend_w = 1'b0;
    end
    // [R16] Narrow switch at own boundary
    if (state_r.pend_n && nar_wrap) begin
      for (int c = 0; c < PDO_NARROW_N; c++) begin
        state_nxt.nar_lat[c] = state_r.buf_q[c+2][6:0];
      end
      state_nxt.pend_n = 1'b0;
    end
    // [R05] Hold clears buffers and latches
    if (hold_i) begin
      state_nxt.sel = PDO_SEL_RESET;
      state_nxt.second = 1'b0;
      state_nxt.buf_q = '0;
      state_nxt.wide_lat = '0;
      state_nxt.nar_lat = '0;
      state_nxt.pend_w = 1'b0;
      state_nxt.pend_n = 1'b0;
    end
    // [R13] Registered busy flag
    state_nxt.busy = state_nxt.pend_w | state_nxt.pend_n;
  end

  // [R04] Latches held between transfers
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_r.sel <= PDO_SEL_RESET;
      state_r.second <= 1'b0;
      state_r.buf_q <= '0;
      state_r.wide_lat <= '0;
      state_r.nar_lat <= '0;
      state_r.pend_w <= 1'b0;
      state_r.pend_n <= 1'b0;
      state_r.busy <= 1'b0;
      state_r.cnt <= '0;
      state_r.wide_out <= 1'b1;
      state_r.nar_out <= '1;
      // [R02] Port latches to one
      state_r.port_latch <= PDO_PORT_LATCH_RESET;
    end else if (clk_en_i) begin
      state_r <= state_nxt;
    end
  end

  // [R13] Busy while any transfer pending
  assign transfer_status_port_o = {3'b000, state_r.busy};
  assign wide_channel_out_o = state_r.wide_out;
  assign narrow_channel_out_o = state_r.nar_out;
  assign port_latch_o = state_r.port_latch;
endmodule

// ### tb/pdo_pwm_dac_assertions.sv
// Checker for the PWM DAC outputs; sees the top module's ports only.
// Assumes the bench keeps clk_en_i high apart from short gaps.
module pdo_pwm_dac_assertions (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic hold_i,
  input wire pdo_pkg::pdo_wr_type buffer_select_port_i,
  input wire pdo_pkg::pdo_wr_type transfer_buffer_port_i,
  input wire logic [9:0] port_latch_wdata_i,
  input wire logic port_latch_wr_i,
  input wire logic [3:0] transfer_status_port_o,
  input wire logic wide_channel_out_o,
  input wire logic [pdo_pkg::PDO_NARROW_N-1:0] narrow_channel_out_o,
  input wire logic [9:0] port_latch_o
);
  import pdo_pkg::*;
  logic [15:0] busy_r;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !transfer_status_port_o[0]) busy_r <= 16'h0;
    else busy_r <= busy_r + 16'h1;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  property p_pad; transfer_status_port_o[3:1] == 3'h0; endproperty
  a_pad: assert property (p_pad) else $error("status pad set");
  property p_go; clk_en_i && !hold_i && buffer_select_port_i.wr &&
    buffer_select_port_i.data == PDO_SEL_TRANSFER |=>
    transfer_status_port_o[0]; endproperty
  a_go: assert property (p_go) else $error("no busy");
  property p_max; busy_r < 16'h8010; endproperty
  a_max: assert property (p_max) else $error("switch late");
  property p_hclr; clk_en_i && hold_i |=> !transfer_status_port_o[0];
  endproperty
  a_hclr: assert property (p_hclr) else $error("hold busy");
  property p_hout; (clk_en_i && hold_i) [*3] |=> wide_channel_out_o &&
    (&narrow_channel_out_o); endproperty
  a_hout: assert property (p_hout) else $error("hold out low");
  property p_rst; $fell(sys_rst_i) |-> port_latch_o == 10'h3ff; endproperty
  a_rst: assert property (p_rst) else $error("latch reset");
  property p_lwr; clk_en_i && port_latch_wr_i |=>
    port_latch_o == $past(port_latch_wdata_i); endproperty
  a_lwr: assert property (p_lwr) else $error("latch write");
  property p_keep; !port_latch_wr_i |=> $stable(port_latch_o); endproperty
  a_keep: assert property (p_keep) else $error("latch moved");
  c_go: cover property ($rose(transfer_status_port_o[0]));
  c_done: cover property ($fell(transfer_status_port_o[0]));
  c_low: cover property (!wide_channel_out_o);
endmodule
bind pdo_pwm_dac pdo_pwm_dac_assertions chk (.*);

// ### tb/pdo_pwm_dac_tb_top.sv
// Bench for the PWM DAC outputs: random data, full-period low counts.
// Assumes the package and the checker are compiled before it.
module pdo_pwm_dac_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pdo_pkg::*;
  logic mclk_i = 0, sys_rst_i = 1, clk_en_i = 1, hold_i = 0, plw = 0;
  pdo_wr_type sel = '0, tbuf = '0;
  logic [9:0] pld = '0, plo;
  logic [3:0] sts;
  logic wo;
  logic [8:0] no;
  logic [13:0] wv;
  logic [6:0] nv [9];
  int n_mismatch = 0, check_count = 0, seed = 32'h2b31, cw, cn [9];
  pdo_pwm_dac dut (.mclk_i, .sys_rst_i, .clk_en_i, .hold_i,
    .buffer_select_port_i(sel), .transfer_buffer_port_i(tbuf),
    .port_latch_wdata_i(pld), .port_latch_wr_i(plw),
    .transfer_status_port_o(sts), .wide_channel_out_o(wo),
    .narrow_channel_out_o(no), .port_latch_o(plo));
  initial begin
    forever #2 mclk_i = ~mclk_i;
  end
  task automatic cyc(int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (e !== g) begin
      n_mismatch++;
      $display("wrong value %s expected %0d seen %0d", s, e, g);
    end
  endtask
  function automatic logic [15:0] exp_w(logic [13:0] v);
    return 16'(128 * v[13:6] + 2 * v[5:0]);
  endfunction
  task automatic wr(bit s, logic [3:0] d);
    @(posedge mclk_i);
    if (s) sel <= '{1'b1, d};
    else tbuf <= '{1'b1, d};
    @(posedge mclk_i);
    sel.wr <= 0;
    tbuf.wr <= 0;
  endtask
  task automatic meas(int n);
    cw = 0;
    cn = '{default: 0};
    repeat (n) begin
      @(negedge mclk_i);
      cw += wo !== 1'b1;
      foreach (cn[i]) cn[i] += no[i] !== 1'b1;
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    cyc(90000);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    logic [7:0] v;
    int t;
    cyc(20);
    sys_rst_i <= 0;
    cyc(1);
    chk("port latch", 16'h3ff, plo);
    pld <= 10'($random(seed));
    plw <= 1;
    clk_en_i <= 0;
    cyc(2);
    clk_en_i <= 1;
    cyc(1);
    plw <= 0;
    cyc(1);
    chk("port latch wr", pld, plo);
    wv = 14'($random(seed));
    foreach (nv[i]) nv[i] = 7'($random(seed));
    nv[0] = 7'h7f;
    nv[8] = 7'h00;
    wr(1, 4'hb);
    wr(0, 4'h5);
    for (int i = 0; i < 11; i++) begin
      v = i == 0 ? 8'(wv[5:0]) : i == 1 ? 8'(wv[13:6]) : 8'(nv[i-2]);
      wr(1, 4'(i));
      wr(0, v[3:0]);
      wr(0, v[7:4]);
    end
    meas(256);
    chk("old wide", 0, 16'(cw));
    foreach (cn[i]) chk("old narrow", 0, 16'(cn[i]));
    wr(1, PDO_SEL_TRANSFER);
    cyc(2);
    chk("busy", 1, sts);
    t = 0;
    while (sts[0] !== 1'b0 && t < 33000) begin
      cyc(1);
      t++;
    end
    chk("switch in time", 1, 16'(t < 33000));
    cyc(2);
    meas(32768);
    chk("wide", exp_w(wv), 16'(cw));
    foreach (cn[i]) chk("narrow", 16'(256 * nv[i]), 16'(cn[i]));
    hold_i <= 1;
    cyc(3);
    hold_i <= 0;
    meas(256);
    chk("held wide", 0, 16'(cw));
    foreach (cn[i]) chk("held narrow", 0, 16'(cn[i]));
    chk("held status", 0, sts);
    give_verdict();
  end
endmodule
